// >>> verif/cmd_props.sv
/* Port checker for the command register block.
   Assumes one ref_clk domain and a synchronous active-high srst. */
`timescale 1ns/1ps
module cmd_props (
  input wire logic                ref_clk,
  input wire logic                srst,
  input wire logic                sclk,
  input wire logic                cs_n,
  input wire logic                sdo,
  input wire logic                sdo_oe,
  input wire logic                load_strobe_pin_n,
  input dac_cmd_pkg::gpio_drive_t gpio_drive,
  input wire logic                group_a_powerdown,
  input wire logic                group_b_powerdown,
  input dac_cmd_pkg::latch_bank_t dac_latch,
  input wire logic [3:0]          gain_sel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  sequence s_frame;
    (!cs_n)[*3];
  endsequence
  property p_rst;
    $fell(srst) |-> gain_sel == 4'hF && gpio_drive.oe == 2'h0 && dac_latch == '0;
  endproperty
  property p_od;
    !cs_n |=> $stable(gpio_drive);
  endproperty
  property p_oe;
    cs_n |-> !sdo_oe;
  endproperty
  property p_sdo;
    (!cs_n && sclk)[*2] |-> $stable(sdo);
  endproperty
  property p_latch;
    s_frame and load_strobe_pin_n[*3] |=> $stable(dac_latch);
  endproperty
  property p_pd;
    s_frame |=> $stable({group_a_powerdown, group_b_powerdown, gain_sel});
  endproperty
  property p_pda;
    $rose(group_a_powerdown) |-> $past(cs_n);
  endproperty
  property p_pdb;
    $changed(group_b_powerdown) |-> $past(cs_n);
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  a_od: assert property (p_od) else $error("pin drive moved in frame");
  a_oe: assert property (p_oe) else $error("sdo enabled idle");
  a_sdo: assert property (p_sdo) else $error("sdo moved");
  a_latch: assert property (p_latch) else $error("latch moved");
  a_pd: assert property (p_pd) else $error("control moved");
  a_pda: assert property (p_pda) else $error("group a late");
  a_pdb: assert property (p_pdb) else $error("group b late");
endmodule
bind dac_command_register_upper cmd_props cmd_props_i (
  .ref_clk(ref_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe),
  .load_strobe_pin_n(load_strobe_pin_n), .gpio_drive(gpio_drive),
  .group_a_powerdown(group_a_powerdown), .group_b_powerdown(group_b_powerdown),
  .dac_latch(dac_latch), .gain_sel(gain_sel));

// >>> verif/spi_host_model.sv
/* Serial host: one 24-bit frame out MSB first, reply collected.
   Assumes the device shifts out after each serial clock fall. */
`timescale 1ns/1ps
module spi_host_model (
  input wire logic ref_clk,
  output logic     sclk,
  output logic     cs_n,
  output logic     sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  import dac_cmd_pkg::*;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  task automatic xfer(input frame_t f, output frame_t r);
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      @(posedge ref_clk);
      cs_n <= 1'b0;
      sclk <= 1'b0;
      sdi  <= f[i];
      repeat (3) @(posedge ref_clk);
      sclk <= 1'b1;
      // A released line reads as the inverse of the bit behind it.
      r[i] = sdo_oe ? sdo : ~sdo;
      @(posedge ref_clk);
    end
    @(posedge ref_clk);
    sclk <= 1'b0;
    cs_n <= 1'b1;
    // Inverted so a device that wrongly keeps sampling sees junk.
    sdi  <= ~sdi;
    repeat (5) @(posedge ref_clk);
  endtask
endmodule

// >>> verif/testbench.sv
/* Self-checking bench for the command register block.
   Assumes the host model owns the serial pins. */
`timescale 1ns/1ps
module testbench;
  import dac_cmd_pkg::*;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        strobe_n = 1'b1;
  logic [1:0]  ext_low = 2'h0;
  wire         sclk, cs_n, sdi, sdo, sdo_oe, pd_a, pd_b;
  gpio_drive_t drv;
  latch_bank_t latch, exp_l;
  logic [3:0]  gain;
  word_t       w, v, x;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #12.5 ref_clk = ~ref_clk;
  dac_command_register_upper dac_command_register_upper_i (
    .ref_clk(ref_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe), .load_strobe_pin_n(strobe_n), .gpio_in(~drv.oe & ~ext_low),
    .gpio_drive(drv), .group_a_powerdown(pd_a), .group_b_powerdown(pd_b),
    .dac_latch(latch), .gain_sel(gain));
  spi_host_model spi_host_model_i (
    .ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
  task automatic chk(input string n, input logic [79:0] e, input logic [79:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input word_t d);
    frame_t r;
    spi_host_model_i.xfer(frame_t'{1'b0, 3'h0, a, d}, r);
  endtask
  task automatic rd(input logic [3:0] a, output word_t d);
    frame_t r;
    spi_host_model_i.xfer(frame_t'{1'b1, 3'h0, a, 16'h0000}, r);
    spi_host_model_i.xfer(frame_t'{1'b1, 3'h0, 4'h1, 16'h0000}, r);
    d = r.data;
  endtask
  function automatic word_t exp_cmd(input word_t d, input logic [1:0] e);
    return (d & 16'h98BC) | {6'h00, d[9:8] & ~e, 8'h00};
  endfunction
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  initial begin
    void'($urandom(76313));
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    rd(ADDR_CMD, v);
    chk("cmd reset", 16'h033C, v);
    for (int i = 0; i < 6; i++) begin
      w = (i < 2) ? (i ? 16'h0000 : 16'h9F7F) : 16'($urandom()) & 16'h9F7F;
      ext_low <= 2'($urandom());
      wr(ADDR_CMD, w);
      rd(ADDR_CMD, v);
      chk("cmd read", exp_cmd(w, ext_low), v);
      chk("ctrl", {w[12:11], ~w[9:8], w[5:2]}, {pd_a, pd_b, drv.oe, gain});
    end
    ext_low <= 2'h0;
    // Output disabled: the host sees a released line, not the reply.
    wr(ADDR_CMD, 16'h0380);
    fork
      rd(ADDR_CMD, v);
      begin
        repeat (20) @(posedge ref_clk);
        chk("sdo_oe off", 1'b0, sdo_oe);
      end
    join
    chk("sdo released", 16'hFC7F, v);
    wr(ADDR_CMD, 16'h0300);
    w = 16'($urandom());
    x = 16'($urandom());
    wr(4'h4, w);
    wr(4'h6, ~w);
    rd(4'h4, v);
    chk("input reg", w, v);
    wr(ADDR_CMD, 16'hC300);
    exp_l = '0;
    exp_l[0] = w;
    exp_l[2] = ~w;
    chk("ld update", exp_l, latch);
    rd(ADDR_CMD, v);
    chk("ld clear", 16'h8300, v);
    wr(4'h5, x);
    rd(4'h5, v);
    chk("latch read", 16'h0000, v);
    strobe_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    exp_l[1] = x;
    chk("strobe update", exp_l, latch);
    wr(4'h7, w);
    wr(ADDR_CMD, 16'hC300);
    chk("ld ignored", exp_l, latch);
    strobe_n <= 1'b1;
    wr(ADDR_CMD, 16'h3B00);
    chk("soft reset", {4'hF, 4'h0, 64'h0}, {gain, drv.oe, pd_a, pd_b, latch});
    rd(ADDR_CMD, v);
    chk("rst clear", 16'h033C, v);
    test_done();
  end
endmodule

// >>> verilog/dac_cmd_pkg.sv
/*
  Shared constants and types for the converter's command register block:
  serial frame layout, register addresses, command bit positions and reset values.
  Assumes a single 40 MHz ref_clk domain in every user of this package.
*/
package dac_cmd_pkg;

  // Serial frame geometry.
  localparam int          FRAME_BITS  = 24;
  localparam int          CNT_W       = 5;
  localparam logic [4:0]  FRAME_LEN   = 5'h18;

  // Register addresses carried in the frame address field.
  localparam logic [3:0]  ADDR_CMD    = 4'h0;
  localparam logic [1:0]  DAC_ADDR_HI = 2'h1;

  // Command register bit positions.
  localparam int          BIT_READ_SEL  = 15;
  localparam int          BIT_LATCH_UPD = 14;
  localparam int          BIT_SOFT_RST  = 13;
  localparam int          BIT_PD_A      = 12;
  localparam int          BIT_PD_B      = 11;
  localparam int          BIT_GPIO1     = 9;
  localparam int          BIT_GPIO0     = 8;
  localparam int          BIT_SDO_DIS   = 7;

  // Reset value and the bits that actually hold state. The strobes, the
  // reserved bits and the no-op bit are not stored. The pin bits are stored
  // for the pin drive but read back as live pin levels.
  localparam logic [15:0] CMD_RESET      = 16'h033C;
  localparam logic [15:0] CMD_STORE_MASK = 16'h9BBC;
  localparam logic [15:0] DATA_RESET     = 16'h0000;
  localparam logic [1:0]  GPIO_RESET     = 2'h3;

  typedef logic [15:0] word_t;
  typedef logic [3:0][15:0] latch_bank_t;

  typedef struct packed {
    logic       rw;
    logic [2:0] pad;
    logic [3:0] addr;
    word_t      data;
  } frame_t;

  typedef struct packed {
    logic [1:0] oe;
    logic [1:0] o;
  } gpio_drive_t;

  function automatic logic is_dac_addr(input logic [3:0] addr);
    return addr[3:2] == DAC_ADDR_HI;
  endfunction

endpackage

// >>> verilog/dac_command_register_upper.sv
/*
  Command register upper byte of a four-channel converter, with the channel
  input registers and latches it steers, the readback path and the two
  open-drain general-purpose pins.
  The frame port shifts the serial frames; this module decodes them, keeps
  the command word and steers the channel latches.
  Assumes all pins are synchronous to ref_clk and the pad logic resolves the
  open-drain pins from gpio_drive.oe. The power-down levels and gain select
  go to the analog section, which is outside this block.
*/
`timescale 1ns/1ps
module dac_command_register_upper
  import dac_cmd_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                srst,
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                sdi,
  output logic                     sdo,
  output logic                     sdo_oe,
  input  wire logic                load_strobe_pin_n,
  input  wire logic [1:0]          gpio_in,
  output dac_cmd_pkg::gpio_drive_t gpio_drive,
  output logic                     group_a_powerdown,
  output logic                     group_b_powerdown,
  output dac_cmd_pkg::latch_bank_t dac_latch,
  output logic [3:0]               gain_sel
);
  import dac_cmd_pkg::*;

  // One-hot select of a channel number.
  function automatic logic [3:0] chan_onehot(input logic [1:0] ch);
    logic [3:0] sel;
    sel     = 4'h0;
    sel[ch] = 1'b1;
    return sel;
  endfunction

  // Readback image of the command word. The strobes and reserved bits come
  // back as zero and the pin bits show the live levels, so a host can tell
  // a pin held low from outside from one that it drives itself.
  function automatic word_t cmd_image(input word_t stored, input logic [1:0] pins);
    word_t img;
    img                      = stored & CMD_STORE_MASK;
    img[BIT_GPIO1:BIT_GPIO0] = pins;
    return img;
  endfunction

  // Reply word for an address: the command image, a channel register, or
  // zero for every address that this block does not hold.
  function automatic word_t reply_word(input logic [3:0] addr, input word_t cmd_img,
                                       input word_t chan_word);
    if (addr == ADDR_CMD) begin
      return cmd_img;
    end
    if (is_dac_addr(addr)) begin
      return chan_word;
    end
    return DATA_RESET;
  endfunction

  word_t        cmd_q;
  latch_bank_t  input_q;
  latch_bank_t  latch_q;
  logic [3:0]   written_q;
  logic         strobe_q;
  logic         soft_rst_q;
  logic         rd_pending_q;
  logic [3:0]   rd_addr_q;

  frame_t       rx_frame;
  frame_t       tx_frame;
  logic         frame_done;

  // The software reset pulse lands one cycle after the frame that asked
  // for it, so the frame itself finishes cleanly before state is cleared.
  wire dev_rst = srst | soft_rst_q;

  serial_frame_port u_port (
    .ref_clk     (ref_clk),
    .srst        (dev_rst),
    .sclk        (sclk),
    .cs_n        (cs_n),
    .sdi         (sdi),
    .sdo_disable (cmd_q[BIT_SDO_DIS]),
    .tx_frame    (tx_frame),
    .sdo         (sdo),
    .sdo_oe      (sdo_oe),
    .frame_done  (frame_done),
    .rx_frame    (rx_frame)
  );

  wire       wr_frame   = frame_done & ~rx_frame.rw;
  wire       rd_frame   = frame_done & rx_frame.rw;
  wire       cmd_wr     = wr_frame & (rx_frame.addr == ADDR_CMD);
  wire       dac_wr     = wr_frame & is_dac_addr(rx_frame.addr);
  wire [1:0] wr_ch      = rx_frame.addr[1:0];

  // The update bit only acts while the strobe pin is high; it is never stored.
  wire ld_pulse    = cmd_wr & rx_frame.data[BIT_LATCH_UPD] & load_strobe_pin_n;
  wire sw_rst_req  = cmd_wr & rx_frame.data[BIT_SOFT_RST];
  wire strobe_fall = strobe_q & ~load_strobe_pin_n;
  wire do_update   = ld_pulse | strobe_fall;

  // Strobe bits, the reserved bits and pin bits read as zero or live levels.
  wire word_t cmd_read = cmd_image(cmd_q, gpio_in);

  wire word_t dac_read = cmd_q[BIT_READ_SEL] ? latch_q[rd_addr_q[1:0]]
                                             : input_q[rd_addr_q[1:0]];

  wire word_t rd_word  = reply_word(rd_addr_q, cmd_read, dac_read);

  assign tx_frame = rd_pending_q ? frame_t'{1'b0, 3'h0, rd_addr_q, rd_word}
                                 : frame_t'(24'h000000);

  assign group_a_powerdown = cmd_q[BIT_PD_A];
  assign group_b_powerdown = cmd_q[BIT_PD_B];
  // The pins are open drain: the output level is always low and only the
  // enable follows the register, so a written one floats the pin.
  assign gpio_drive        = '{oe: ~cmd_q[BIT_GPIO1:BIT_GPIO0], o: 2'h0};
  assign dac_latch         = latch_q;
  assign gain_sel          = cmd_q[5:2];

  // The pulse drives the device reset, so only srst may clear it; it drops
  // by itself after one cycle, and the bit reads back as zero because it is never stored.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= sw_rst_req & ~soft_rst_q;
    end
  end

  // Only bits that hold state are kept; the strobes act on the write itself
  // and leave nothing behind in the stored word.
  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      cmd_q <= CMD_RESET;
    end else if (cmd_wr) begin
      cmd_q <= (rx_frame.data & CMD_STORE_MASK) | 16'h0000;
    end
  end

  // A read command only arms the reply; the word is gathered when the next
  // frame opens, so the pin bits show their levels at that moment.
  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      rd_pending_q <= 1'b0;
      rd_addr_q    <= ADDR_CMD;
    end else if (frame_done) begin
      rd_pending_q <= rd_frame;
      rd_addr_q    <= rx_frame.addr;
    end
  end

  // A pin held low through reset looks like a fall once reset ends; that is
  // harmless because no channel has a pending write at that point.
  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      strobe_q <= 1'b1;
    end else begin
      strobe_q <= load_strobe_pin_n;
    end
  end

  // One-hot mark of the channel that a data frame writes and a mask of the
  // channels that reload on this update.
  wire [3:0] ch_wr_sel = dac_wr ? chan_onehot(wr_ch) : 4'h0;
  wire [3:0] ch_load   = do_update ? written_q : 4'h0;

  // A write landing in the same cycle as an update keeps its pending mark,
  // so the new value waits for the next update instead of being lost.
  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      written_q <= 4'h0;
    end else begin
      written_q <= ch_wr_sel | (written_q & ~ch_load);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      input_q <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ch_wr_sel[i]) begin
          input_q[i] <= rx_frame.data;
        end
      end
    end
  end

  // Channels without a pending write keep their latch, which spares their
  // outputs a needless glitch on every update.
  always_ff @(posedge ref_clk) begin
    if (dev_rst) begin
      latch_q <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (ch_load[i]) begin
          latch_q[i] <= input_q[i];
        end
      end
    end
  end

endmodule

// >>> verilog/serial_frame_port.sv
/*
  Serial frame port: shifts a 24-bit frame in on sclk rising edges and a
  reply frame out on sclk falling edges while cs_n is low.
  Assumes sclk, cs_n and sdi are synchronous to ref_clk and sclk runs well
  below half the ref_clk rate.
*/
`timescale 1ns/1ps
module serial_frame_port
  import dac_cmd_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              srst,
  input  wire logic              sclk,
  input  wire logic              cs_n,
  input  wire logic              sdi,
  input  wire logic              sdo_disable,
  input  dac_cmd_pkg::frame_t    tx_frame,
  output logic                   sdo,
  output logic                   sdo_oe,
  output logic                   frame_done,
  output dac_cmd_pkg::frame_t    rx_frame
);
  import dac_cmd_pkg::*;

  logic              sclk_q;
  logic              cs_n_q;
  logic [CNT_W-1:0]  cnt_q;
  frame_t            in_q;
  frame_t            out_q;

  wire sclk_rise  = sclk & ~sclk_q & ~cs_n;
  wire sclk_fall  = ~sclk & sclk_q & ~cs_n;
  wire cs_start   = ~cs_n & cs_n_q;
  wire cs_end     = cs_n & ~cs_n_q;

  // A frame of any other length is dropped whole rather than half applied.
  assign frame_done = cs_end & (cnt_q == FRAME_LEN);
  assign rx_frame   = in_q;
  assign sdo        = out_q[FRAME_BITS-1];
  assign sdo_oe     = ~cs_n & ~sdo_disable;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      cnt_q  <= '0;
      in_q   <= '0;
      out_q  <= '0;
    end else begin
      sclk_q <= sclk;
      cs_n_q <= cs_n;
      if (cs_start) begin
        cnt_q <= '0;
        out_q <= tx_frame;
      end else begin
        if (sclk_rise) begin
          in_q  <= {in_q[FRAME_BITS-2:0], sdi};
          // The count stops at all ones, so an overlong frame never matches.
          cnt_q <= (&cnt_q) ? cnt_q : cnt_q + 5'h01;
        end
        if (sclk_fall) begin
          out_q <= {out_q[FRAME_BITS-2:0], 1'b0};
        end
      end
    end
  end

endmodule
